/* File: include/hrp_pkg.sv */
// constants shared by both ends of the host register port
package hrp_pkg;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 32;
  localparam int BE_W = 4;
  localparam int EVT_W = 4;
  // ****************************************************************
  // register word indices
  // ****************************************************************
  localparam logic [15:0] REG_STATUS = 16'h0000;
  localparam logic [15:0] REG_IRQ_EN = 16'h0001;
  localparam logic [15:0] REG_L1_SETUP = 16'h0002;
  localparam logic [15:0] REG_CW_INDEX = 16'h0003;
  localparam logic [15:0] REG_CW_RX = 16'h0004;
  localparam logic [15:0] REG_CW_TX = 16'h0005;
  localparam int BYTE_ADDR_SHIFT = 2;
  // ****************************************************************
  // field layouts and reset values
  // ****************************************************************
  localparam int IDX_RX_X_LSB = 0;
  localparam int IDX_RX_SEQ_LSB = 8;
  localparam int IDX_TX_X_LSB = 16;
  localparam int IDX_TX_SEQ_LSB = 24;
  localparam logic [31:0] IDX_WMASK = 32'h0FFF0FFF;
  localparam int L1_TX_CW_EN_BIT = 0;
  localparam int L1_RATE_LSB = 4;
  localparam logic [31:0] L1_WMASK = 32'h000000F1;
  localparam logic [31:0] IRQ_EN_WMASK = 32'h0000000F;
  localparam logic [31:0] RST_STATUS = 32'h00000000;
  localparam logic [31:0] RST_IRQ_EN = 32'h00000000;
  localparam logic [31:0] RST_L1_SETUP = 32'h00000000;
  localparam logic [31:0] RST_CW_INDEX = 32'h00000000;
  // ****************************************************************
  // control word table geometry
  // ****************************************************************
  localparam int CW_COUNT = 256;
  localparam int CW_SUBCH = 64;
  localparam int CW_SECTIONS = 12;
  localparam int CW_X_W = 8;
  localparam int CW_SEQ_W = 4;
  typedef enum {H_IDLE, H_BUSY} hrp_host_state_e;
endpackage

/* File: include/hrp_cpu_if.sv */
// register port wires between processor end and device end
`timescale 1ns/1ns
interface hrp_cpu_if;
  logic [15:0] address;
  logic [3:0] byteenable;
  logic read;
  logic write;
  logic [31:0] writedata;
  logic [31:0] readdata;
  logic waitrequest;
  logic irq;
  modport dev (
    input address, byteenable, read, write, writedata,
    output readdata, waitrequest, irq
  );
  modport host (
    output address, byteenable, read, write, writedata,
    input readdata, waitrequest, irq
  );
endinterface

/* File: src/hrp_dev_end.sv */
// device end: register slave with indexed control word tables
// Contract
// - reads answer next cycle, most writes zero-wait
// - slow registers may stretch write via wait
// - one single-beat access per register
// - everything on the port clock
// - reset clears port logic and registers
// - master holds reset one full cycle
// - address is word index, or byte optionally
// - all registers are 32 bits wide
// - master strobes read or write with address
// - wait high while busy, low means done
// - enabled interrupt sources raise single irq
// - master reads status to find cause
// - build option exposes all 256 control words
// - rx word: set index, then read rx
// - tx word: setup, index, then tx register
// - index is subchannel plus 64 times position
// - index fields select next rx/tx word
// - register access only where timing is relaxed
// - sequence field picks 32-bit section
// - first byte sits in bits 31:24
`timescale 1ns/1ns
module hrp_dev_end
  import hrp_pkg::*;
#(
  parameter bit ALL_CW_ACCESS = 1'b1,
  parameter bit BYTE_ADDR = 1'b0
) (
  input wire logic sys_clk,
  input wire logic resetn,
  hrp_cpu_if.dev bus,
  input wire logic rx_cw_wr_en,
  input wire logic [7:0] rx_cw_wr_index,
  input wire logic [3:0] rx_cw_wr_seq,
  input wire logic [31:0] rx_cw_wr_data,
  input wire logic [7:0] tx_cw_rd_index,
  input wire logic [3:0] tx_cw_rd_seq,
  output logic [31:0] tx_cw_rd_data,
  output logic tx_cw_insert_en,
  output logic [3:0] line_rate_sel,
  input wire logic [3:0] irq_events
);
  // ****************************************************************
  // state
  // ****************************************************************
  logic [31:0] status;
  logic [31:0] irq_en;
  logic [31:0] l1_setup;
  logic [31:0] cw_index;
  logic rd_pend;
  logic wr_pend;
  logic [31:0] rdata;
  logic irq_q;
  logic [31:0] next_status;
  logic [31:0] next_irq_en;
  logic [31:0] next_l1_setup;
  logic [31:0] next_cw_index;
  logic next_rd_pend;
  logic next_wr_pend;
  logic [31:0] next_rdata;
  logic next_irq_q;
  logic [31:0] rx_tab [CW_COUNT][CW_SECTIONS];
  logic [31:0] tx_tab [CW_COUNT][CW_SECTIONS];
  logic [15:0] reg_idx;
  logic tx_hit;
  logic wr_take;
  logic [7:0] rx_x;
  logic [3:0] rx_seq;
  logic [7:0] tx_x;
  logic [3:0] tx_seq;
  logic tx_wr_en;
  logic [31:0] next_tx_cw_rd_data;

  function automatic logic [31:0] be_merge(
    input logic [31:0] old_v,
    input logic [31:0] new_v,
    input logic [3:0] be,
    input logic [31:0] wmask
  );
    logic [31:0] m;
    m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}} & wmask;
    return (old_v & ~m) | (new_v & m);
  endfunction

  // ****************************************************************
  // address decode and handshake
  // ****************************************************************
  always_comb begin
    if (BYTE_ADDR) begin
      reg_idx = bus.address >> BYTE_ADDR_SHIFT;
    end else begin
      reg_idx = bus.address;
    end
  end

  assign rx_x = cw_index[IDX_RX_X_LSB +: CW_X_W];
  assign rx_seq = cw_index[IDX_RX_SEQ_LSB +: CW_SEQ_W];
  assign tx_x = cw_index[IDX_TX_X_LSB +: CW_X_W];
  assign tx_seq = cw_index[IDX_TX_SEQ_LSB +: CW_SEQ_W];
  assign tx_hit = ALL_CW_ACCESS && (reg_idx == REG_CW_TX);
  // table write needs one extra cycle, other writes finish at once
  assign bus.waitrequest = (bus.read & ~rd_pend)
                         | (bus.write & tx_hit & ~wr_pend);
  assign wr_take = bus.write & ~bus.waitrequest;
  assign tx_wr_en = wr_take && tx_hit
                    && (int'(tx_seq) < CW_SECTIONS);
  assign bus.readdata = rdata;
  assign bus.irq = irq_q;
  assign tx_cw_insert_en = l1_setup[L1_TX_CW_EN_BIT];
  assign line_rate_sel = l1_setup[L1_RATE_LSB +: 4];

  // ****************************************************************
  // register next values
  // ****************************************************************
  always_comb begin
    next_rd_pend = bus.read & ~rd_pend;
    next_wr_pend = bus.write & tx_hit & ~wr_pend;
    next_irq_en = irq_en;
    next_l1_setup = l1_setup;
    next_cw_index = cw_index;
    next_status = status;
    if (wr_take) begin
      case (reg_idx)
        REG_STATUS: begin
          next_status = status & ~(bus.writedata
                        & {{8{bus.byteenable[3]}}, {8{bus.byteenable[2]}},
                           {8{bus.byteenable[1]}}, {8{bus.byteenable[0]}}});
        end
        REG_IRQ_EN: begin
          next_irq_en = be_merge(irq_en, bus.writedata, bus.byteenable,
                                 IRQ_EN_WMASK);
        end
        REG_L1_SETUP: begin
          next_l1_setup = be_merge(l1_setup, bus.writedata,
                                   bus.byteenable, L1_WMASK);
        end
        REG_CW_INDEX: begin
          next_cw_index = be_merge(cw_index, bus.writedata,
                                   bus.byteenable, IDX_WMASK);
        end
        default: begin
        end
      endcase
    end
    // an event in the clearing cycle stays set
    next_status[EVT_W-1:0] = next_status[EVT_W-1:0] | irq_events;
    next_irq_q = |(next_status[EVT_W-1:0]
                   & next_irq_en[EVT_W-1:0]);
    next_rdata = rdata;
    if (bus.read && !rd_pend) begin
      next_rdata = '0;
      case (reg_idx)
        REG_STATUS: next_rdata = status;
        REG_IRQ_EN: next_rdata = irq_en;
        REG_L1_SETUP: next_rdata = l1_setup;
        REG_CW_INDEX: next_rdata = cw_index;
        REG_CW_RX: begin
          if (ALL_CW_ACCESS && int'(rx_seq) < CW_SECTIONS) begin
            next_rdata = rx_tab[rx_x][rx_seq];
          end
        end
        REG_CW_TX: begin
          if (ALL_CW_ACCESS && int'(tx_seq) < CW_SECTIONS) begin
            next_rdata = tx_tab[tx_x][tx_seq];
          end
        end
        default: next_rdata = '0;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      status <= RST_STATUS;
      irq_en <= RST_IRQ_EN;
      l1_setup <= RST_L1_SETUP;
      cw_index <= RST_CW_INDEX;
      rd_pend <= 1'b0;
      wr_pend <= 1'b0;
      rdata <= '0;
      irq_q <= 1'b0;
    end else begin
      status <= next_status;
      irq_en <= next_irq_en;
      l1_setup <= next_l1_setup;
      cw_index <= next_cw_index;
      rd_pend <= next_rd_pend;
      wr_pend <= next_wr_pend;
      rdata <= next_rdata;
      irq_q <= next_irq_q;
    end
  end

  // ****************************************************************
  // control word tables, table row = subchannel + 64 * position
  // ****************************************************************
  always_ff @(posedge sys_clk) begin
    if (ALL_CW_ACCESS && rx_cw_wr_en && int'(rx_cw_wr_seq) < CW_SECTIONS) begin
      rx_tab[rx_cw_wr_index][rx_cw_wr_seq] <= rx_cw_wr_data;
    end
    if (tx_wr_en) begin
      tx_tab[tx_x][tx_seq] <= bus.writedata;
    end
  end

  always_comb begin
    next_tx_cw_rd_data = '0;
    if (int'(tx_cw_rd_seq) < CW_SECTIONS) begin
      next_tx_cw_rd_data = tx_tab[tx_cw_rd_index][tx_cw_rd_seq];
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      tx_cw_rd_data <= '0;
    end else begin
      tx_cw_rd_data <= next_tx_cw_rd_data;
    end
  end
endmodule

/* File: src/hrp_host_end.sv */
// processor end: single-beat register master
`timescale 1ns/1ns
module hrp_host_end
  import hrp_pkg::*;
#(
  parameter bit BYTE_ADDR = 1'b0
) (
  input wire logic sys_clk,
  input wire logic resetn,
  hrp_cpu_if.host bus,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic cmd_write,
  input wire logic [15:0] cmd_index,
  input wire logic [3:0] cmd_be,
  input wire logic [31:0] cmd_wdata,
  output logic rsp_valid,
  output logic [31:0] rsp_rdata,
  output logic irq_seen
);
  // ****************************************************************
  // state
  // ****************************************************************
  hrp_host_state_e state;
  hrp_host_state_e next_state;
  logic rd_q;
  logic wr_q;
  logic [15:0] addr_q;
  logic [3:0] be_q;
  logic [31:0] wdata_q;
  logic rsp_q;
  logic [31:0] rdata_q;
  logic next_rd_q;
  logic next_wr_q;
  logic [15:0] next_addr_q;
  logic [3:0] next_be_q;
  logic [31:0] next_wdata_q;
  logic next_rsp_q;
  logic [31:0] next_rdata_q;

  assign cmd_ready = (state == H_IDLE);
  assign bus.read = rd_q;
  assign bus.write = wr_q;
  assign bus.address = addr_q;
  assign bus.byteenable = be_q;
  assign bus.writedata = wdata_q;
  assign rsp_valid = rsp_q;
  assign rsp_rdata = rdata_q;
  assign irq_seen = bus.irq;

  // ****************************************************************
  // one access at a time, held until wait drops
  // ****************************************************************
  always_comb begin
    next_state = state;
    next_rd_q = rd_q;
    next_wr_q = wr_q;
    next_addr_q = addr_q;
    next_be_q = be_q;
    next_wdata_q = wdata_q;
    next_rsp_q = 1'b0;
    next_rdata_q = rdata_q;
    case (state)
      H_IDLE: begin
        if (cmd_valid) begin
          next_state = H_BUSY;
          next_rd_q = ~cmd_write;
          next_wr_q = cmd_write;
          next_be_q = cmd_be;
          next_wdata_q = cmd_wdata;
          if (BYTE_ADDR) begin
            next_addr_q = cmd_index << BYTE_ADDR_SHIFT;
          end else begin
            next_addr_q = cmd_index;
          end
        end
      end
      H_BUSY: begin
        if (!bus.waitrequest) begin
          next_state = H_IDLE;
          next_rd_q = 1'b0;
          next_wr_q = 1'b0;
          next_rsp_q = 1'b1;
          if (rd_q) begin
            next_rdata_q = bus.readdata;
          end
        end
      end
      default: next_state = H_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state <= H_IDLE;
      rd_q <= 1'b0;
      wr_q <= 1'b0;
      addr_q <= '0;
      be_q <= '0;
      wdata_q <= '0;
      rsp_q <= 1'b0;
      rdata_q <= '0;
    end else begin
      state <= next_state;
      rd_q <= next_rd_q;
      wr_q <= next_wr_q;
      addr_q <= next_addr_q;
      be_q <= next_be_q;
      wdata_q <= next_wdata_q;
      rsp_q <= next_rsp_q;
      rdata_q <= next_rdata_q;
    end
  end
endmodule

/* File: tb/hrp_chk_sva.sv */
// checker for the register port wires between both ends
`timescale 1ns/1ns
module hrp_chk
  import hrp_pkg::*;
(
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic [15:0] address,
  input wire logic [3:0] byteenable,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  input wire logic irq
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  // ****************************************************************
  // transfer timing
  // ****************************************************************
  AST_RD_FIRST: assert property ($rose(read) |-> waitrequest)
    else $error("read not held off in its request cycle");
  AST_RD_ONE: assert property (
    read && waitrequest |=> read && !waitrequest)
    else $error("read answer not one cycle later");
  AST_WR_ZERO: assert property (
    write && address != REG_CW_TX |-> !waitrequest)
    else $error("plain write was stretched");
  AST_TX_STRETCH: assert property (
    $rose(write) && address == REG_CW_TX |->
    waitrequest ##1 (write && !waitrequest))
    else $error("tx word write not stretched by one cycle");
  AST_ONE_KIND: assert property (!(read && write))
    else $error("read and write together");
  AST_SINGLE: assert property (
    (read || write) && !waitrequest |=> !read && !write)
    else $error("strobe kept after completion");
  AST_REQ_HOLD: assert property (
    (read || write) && waitrequest |=>
    $stable({address, byteenable, read, write, writedata}))
    else $error("request changed while held off");
  AST_IDLE: assert property (!read && !write |-> !waitrequest)
    else $error("wait raised with no request");
  AST_RDATA_HOLD: assert property (!read |=> $stable(readdata))
    else $error("read data moved without a read");
  AST_RST: assert property (
    $rose(resetn) |-> readdata == 32'h0 && !irq)
    else $error("outputs not cleared by reset");
  cover property (read && !waitrequest);
  cover property (write && waitrequest);
  cover property ($rose(irq));
endmodule

/* File: tb/host_register_port_ctrl_word_index_tb.sv */
// testbench joining processor end and device end
`timescale 1ns/1ns
module host_register_port_ctrl_word_index_tb
  import hrp_pkg::*;
;
  logic sys_clk, resetn, cmd_valid, cmd_write, cmd_ready, rsp_valid;
  logic irq_seen, rx_cw_wr_en, tx_cw_insert_en;
  logic [15:0] cmd_index;
  logic [3:0] cmd_be, rx_cw_wr_seq, tx_cw_rd_seq, line_rate_sel, irq_events, s;
  logic [31:0] cmd_wdata, rsp_rdata, rx_cw_wr_data, tx_cw_rd_data, d;
  logic [7:0] rx_cw_wr_index, tx_cw_rd_index, x;
  logic [32:0] exp_q[$];
  logic [32:0] e;
  int fail_count, samples_checked, cyc;
  int seed = 52422;
  hrp_cpu_if hrp_cpu_if_i();
  hrp_dev_end hrp_dev_end_i(.sys_clk, .resetn, .bus(hrp_cpu_if_i),
    .rx_cw_wr_en, .rx_cw_wr_index, .rx_cw_wr_seq, .rx_cw_wr_data,
    .tx_cw_rd_index, .tx_cw_rd_seq, .tx_cw_rd_data, .tx_cw_insert_en,
    .line_rate_sel, .irq_events);
  hrp_host_end hrp_host_end_i(.sys_clk, .resetn, .bus(hrp_cpu_if_i),
    .cmd_valid, .cmd_ready, .cmd_write, .cmd_index, .cmd_be, .cmd_wdata,
    .rsp_valid, .rsp_rdata, .irq_seen);
  hrp_chk hrp_chk_i(.sys_clk, .resetn, .address(hrp_cpu_if_i.address),
    .byteenable(hrp_cpu_if_i.byteenable), .read(hrp_cpu_if_i.read),
    .write(hrp_cpu_if_i.write), .writedata(hrp_cpu_if_i.writedata),
    .readdata(hrp_cpu_if_i.readdata), .irq(hrp_cpu_if_i.irq),
    .waitrequest(hrp_cpu_if_i.waitrequest));
  // ****************************************************************
  // helpers
  // ****************************************************************
  task automatic chk(input string n, input logic [31:0] ev,
                     input logic [31:0] sv);
    samples_checked++;
    if (sv !== ev) begin
      fail_count++;
      $display("BAD %s exp %h got %h", n, ev, sv);
    end
  endtask
  task automatic close_out();
    if (fail_count == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic acc(input logic w, input logic [15:0] a, input logic [3:0] b,
                     input logic [31:0] wd, input logic [31:0] ex);
    int n;
    exp_q.push_back({!w, ex});
    @(posedge sys_clk);
    #1;
    chk("cmd_ready", 32'h1, 32'(cmd_ready));
    cmd_valid = 1'b1;
    cmd_write = w;
    cmd_index = a;
    cmd_be = b;
    cmd_wdata = wd;
    @(posedge sys_clk);
    #1;
    cmd_valid = 1'b0;
    chk("cmd_ready", 32'h0, 32'(cmd_ready));
    n = 0;
    while (rsp_valid !== 1'b1 && n < 20) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    if (n >= 20) begin
      fail_count++;
    end
  endtask
  task automatic rx_put(input logic [7:0] xi, input logic [3:0] si,
                        input logic [31:0] v);
    @(posedge sys_clk);
    #1;
    rx_cw_wr_en = 1'b1;
    rx_cw_wr_index = xi;
    rx_cw_wr_seq = si;
    rx_cw_wr_data = v;
    @(posedge sys_clk);
    #1;
    rx_cw_wr_en = 1'b0;
  endtask
  task automatic ev_irq(input logic [3:0] v, input logic want);
    irq_events = v;
    @(posedge sys_clk);
    #1;
    irq_events = 4'h0;
    repeat (2) @(posedge sys_clk);
    #1;
    chk("irq_seen", 32'(want), 32'(irq_seen));
  endtask
  // ****************************************************************
  // clock, watchdog, response monitor
  // ****************************************************************
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc > 3000) begin
      fail_count++;
      close_out();
    end
  end
  always @(negedge sys_clk) begin
    if (rsp_valid === 1'b1) begin
      e = (exp_q.size() > 0) ? exp_q.pop_front() : 33'h1FFFFFFFF;
      if (e[32]) chk("rsp_rdata", e[31:0], rsp_rdata);
    end
  end
  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    {resetn, cmd_valid, cmd_write, cmd_index, cmd_be, cmd_wdata} = '0;
    {rx_cw_wr_en, rx_cw_wr_index, rx_cw_wr_seq, rx_cw_wr_data} = '0;
    {tx_cw_rd_index, tx_cw_rd_seq, irq_events} = '0;
    repeat (4) @(posedge sys_clk);
    #1;
    resetn = 1'b1;
    for (int i = 0; i < 5; i++) begin
      acc(0, (i < 4) ? 16'(i) : 16'h0040, 4'hF, 0, 0);
    end
    for (int i = 1; i < 4; i++) begin
      d = $random(seed);
      acc(1, 16'(i), 4'hF, d, 0);
      acc(0, 16'(i), 4'hF, 0, d & (i == 1 ? IRQ_EN_WMASK :
        (i == 2 ? L1_WMASK : IDX_WMASK)));
      if (i == 2) begin
        chk("setup", 32'({d[7:4], d[0]}),
          32'({line_rate_sel, tx_cw_insert_en}));
      end
    end
    acc(1, REG_CW_INDEX, 4'hF, 0, 0);
    acc(1, REG_CW_INDEX, 4'h1, 32'hFFFFFFFF, 0);
    acc(0, REG_CW_INDEX, 4'hF, 0, 32'h000000FF);
    for (int xs = 0; xs < 4; xs++) begin
      s = 4'($unsigned($random(seed)) % CW_SECTIONS);
      d = $random(seed);
      x = 8'(16 + CW_SUBCH * xs);
      rx_put(x, s, d);
      acc(1, REG_CW_INDEX, 4'hF, {20'h0, s, x}, 0);
      acc(0, REG_CW_RX, 4'hF, 0, d);
    end
    acc(1, REG_CW_INDEX, 4'hF, {20'h0, 4'hC, x}, 0);
    acc(0, REG_CW_RX, 4'hF, 0, 0);
    acc(1, REG_L1_SETUP, 4'hF, 32'h1, 0);
    acc(1, REG_CW_INDEX, 4'hF, {4'h0, s, x, 16'h0}, 0);
    d = $random(seed);
    acc(1, REG_CW_TX, 4'hF, d, 0);
    acc(0, REG_CW_TX, 4'hF, 0, d);
    tx_cw_rd_index = x;
    tx_cw_rd_seq = s;
    @(posedge sys_clk);
    #1;
    chk("tx_cw_rd_data", d, tx_cw_rd_data);
    chk("insert", 32'h1, 32'(tx_cw_insert_en));
    acc(1, REG_IRQ_EN, 4'hF, 32'h2, 0);
    ev_irq(4'h1, 1'b0);
    acc(0, REG_STATUS, 4'hF, 0, 32'h1);
    ev_irq(4'h2, 1'b1);
    acc(0, REG_STATUS, 4'hF, 0, 32'h3);
    acc(1, REG_STATUS, 4'hF, 32'h3, 0);
    ev_irq(4'h0, 1'b0);
    resetn = 1'b0;
    repeat (2) @(posedge sys_clk);
    #1;
    resetn = 1'b1;
    acc(0, REG_L1_SETUP, 4'hF, 0, 0);
    // let the monitor take the last response off the queue
    @(posedge sys_clk);
    #1;
    chk("setup", 32'h0, 32'({line_rate_sel, tx_cw_insert_en}));
    chk("pending", 32'h0, 32'(exp_q.size()));
    close_out();
  end
endmodule
